// File: core/clock_multiplier_control.sv
/*
  Clock multiplier control: control register, bring-up sequencer,
  ratio selection, external oscillator pin claim, interrupt flags,
  classic Wishbone slave.
  Assumes one 125 MHz clock, synchronous active-high reset and a
  single-cycle Wishbone master that holds its request until ack.
*/
// Register access over Wishbone was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "clock_multiplier_control_regs.svh"

module clock_multiplier_control
  import clock_multiplier_control_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:2] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  output logic mul_enable_o,
  output logic mul_ready_o,
  output logic mul_src_ext_o,
  output logic [3:0] mul_num_o,
  output logic [2:0] mul_den_o,
  output logic crystal_pin_a_claim_o,
  output logic crystal_pin_b_claim_o,
  output logic crystal_pin_b_digital_o
);

  localparam int SETTLE_CYC =
    (`CM_SETTLE_NS * `CM_CLK_MHZ + 999) / 1000;
  localparam logic [7:0] SETTLE_LD = 8'(SETTLE_CYC - 1);

  mul_ctl_t ctl_q, ctl_d;
  mul_state_t st_q, st_d;
  logic [7:0] cnt_q, cnt_d;
  logic [2:0] xosc_q, xosc_d;
  logic [1:0] stat_q, stat_d;
  logic [1:0] mask_q, mask_d;
  logic ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;
  logic irq_q, irq_d;
  mul_ratio_t ratio_q, ratio_d;
  logic pa_q, pa_d, pb_q, pb_d, pd_q, pd_d;

  logic req, wr, rd;
  logic hit_ctl, hit_xosc, hit_stat, hit_mask;
  logic rdy_rise, rdy_fall;

  assign req = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr = req && wb_we_i && wb_sel_i[0];
  assign rd = req && !wb_we_i;
  assign hit_ctl = wb_adr_i == `CM_IDX_CTL;
  assign hit_xosc = wb_adr_i == `CM_IDX_XOSC;
  assign hit_stat = wb_adr_i == `CM_IDX_STAT;
  assign hit_mask = wb_adr_i == `CM_IDX_MASK;

  // Control register and bring-up sequencer
  always_comb
  begin
    ctl_d = ctl_q;
    st_d = st_q;
    cnt_d = cnt_q;
    if (wr && hit_ctl)
    begin
      ctl_d.en = wb_dat_i[`CM_BIT_EN];
      ctl_d.div = wb_dat_i[`CM_DIV_LSB +: 3];
      ctl_d.sel = wb_dat_i[`CM_SEL_LSB +: 2];
      // Init only counts when enable was already set
      ctl_d.init = ctl_q.en && wb_dat_i[`CM_BIT_EN] &&
        (ctl_q.init || wb_dat_i[`CM_BIT_INIT]);
    end
    if (!ctl_d.en)
    begin
      st_d = ST_OFF;
      ctl_d.init = 1'b0;
    end
    else
    begin
      unique case (st_q)
        ST_OFF:
          st_d = ST_WAIT_INIT;
        ST_WAIT_INIT:
          if (ctl_d.init)
          begin
            st_d = ST_SETTLE;
            cnt_d = SETTLE_LD;
          end
        ST_SETTLE:
          if (cnt_q == 8'h00)
            st_d = ST_READY;
          else
            cnt_d = cnt_q - 8'h01;
        ST_READY:
          st_d = ST_READY;
      endcase
      // A fresh init request restarts the settle period
      if (wr && hit_ctl && wb_dat_i[`CM_BIT_INIT] && ctl_q.en &&
          st_q != ST_WAIT_INIT)
      begin
        st_d = ST_SETTLE;
        cnt_d = SETTLE_LD;
      end
    end
  end

  // Ratio: base x2 or x4, scale num/den as 2/(code+1) for codes 2 to 6 unless sel is 00
  always_comb
  begin
    ratio_d.src_ext = ctl_q.sel[0];
    ratio_d.num = ctl_q.sel[1] ? 4'h4 : 4'h2;
    ratio_d.den = 3'h1;
    // Reserved 111 falls back to unscaled
    if (ctl_q.sel != 2'b00 && ctl_q.div >= 3'h2 &&
        ctl_q.div != 3'h7)
    begin
      ratio_d.num = {ratio_d.num[2:0], 1'b0};
      ratio_d.den = ctl_q.div + 3'h1;
    end
  end

  // External oscillator mode and pin ownership
  always_comb
  begin
    xosc_d = xosc_q;
    if (wr && hit_xosc)
      xosc_d = wb_dat_i[`CM_XOSC_LSB +: 3];
    pa_d = xosc_q[2:1] == 2'b11;
    pb_d = xosc_q[2] || xosc_q[1];
    pd_d = xosc_q[2:1] == 2'b01;
  end

  // Sticky events: bit0 ready rose, bit1 ready lost
  assign rdy_rise = st_d == ST_READY && st_q != ST_READY;
  assign rdy_fall = st_d != ST_READY && st_q == ST_READY;

  always_comb
  begin
    stat_d = stat_q;
    mask_d = mask_q;
    if (rd && hit_stat)
      stat_d = 2'b00;
    if (wr && hit_mask)
      mask_d = wb_dat_i[1:0];
    // Set wins over the clearing read
    stat_d = stat_d | {rdy_fall, rdy_rise};
    irq_d = |(stat_d & mask_d);
  end

  // Bus answer, one cycle after the request is seen
  always_comb
  begin
    ack_d = req;
    rdat_d = 32'h0000_0000;
    if (rd)
    begin
      if (hit_ctl)
        rdat_d[7:0] = {ctl_q.en, ctl_q.init,
          st_q == ST_READY, ctl_q.div, ctl_q.sel};
      else if (hit_xosc)
        rdat_d[7:0] = {1'b0, xosc_q, 4'h0};
      else if (hit_stat)
        rdat_d[1:0] = stat_q;
      else if (hit_mask)
        rdat_d[1:0] = mask_q;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      // Ready bit is not stored, so the reset word is cut to 7 bits
      ctl_q <= mul_ctl_t'(7'(`CM_CTL_RST));
      st_q <= ST_OFF;
      cnt_q <= 8'h00;
      xosc_q <= `CM_XOSC_RST;
      stat_q <= `CM_IRQ_RST;
      mask_q <= `CM_IRQ_RST;
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
      irq_q <= 1'b0;
      ratio_q <= '0;
      pa_q <= 1'b0;
      pb_q <= 1'b0;
      pd_q <= 1'b0;
    end
    else
    begin
      ctl_q <= ctl_d;
      st_q <= st_d;
      cnt_q <= cnt_d;
      xosc_q <= xosc_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      ack_q <= ack_d;
      rdat_q <= rdat_d;
      irq_q <= irq_d;
      ratio_q <= ratio_d;
      pa_q <= pa_d;
      pb_q <= pb_d;
      pd_q <= pd_d;
    end
  end

  logic en_out_q, rdy_out_q;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      en_out_q <= 1'b0;
      rdy_out_q <= 1'b0;
    end
    else
    begin
      en_out_q <= ctl_q.en;
      rdy_out_q <= st_q == ST_READY;
    end
  end

  assign wb_dat_o = rdat_q;
  assign wb_ack_o = ack_q;
  assign irq_o = irq_q;
  assign mul_enable_o = en_out_q;
  assign mul_ready_o = rdy_out_q;
  assign mul_src_ext_o = ratio_q.src_ext;
  assign mul_num_o = ratio_q.num;
  assign mul_den_o = ratio_q.den;
  assign crystal_pin_a_claim_o = pa_q;
  assign crystal_pin_b_claim_o = pb_q;
  assign crystal_pin_b_digital_o = pd_q;

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_EN_FOLLOWS: assert property (
    ctl_q.en |=> mul_enable_o) else $error("enable not passed out");
  AST_DIS_DROPS: assert property (
    !ctl_q.en |=> !mul_enable_o && !mul_ready_o)
    else $error("disabled multiplier still active");
  AST_INIT_STARTS: assert property (
    wr && hit_ctl && ctl_q.en && wb_dat_i[`CM_BIT_EN] &&
    wb_dat_i[`CM_BIT_INIT] |=> st_q == ST_SETTLE)
    else $error("init did not start settling");
  AST_INIT_ZERO: assert property (
    $rose(ctl_q.en) |-> !ctl_q.init)
    else $error("init set on enabling");
  // Ready only after the settle count has run out
  AST_RDY_TIME: assert property (
    $rose(st_q == ST_READY) |->
    $past(st_q) == ST_SETTLE && $past(cnt_q) == 8'h00)
    else $error("ready too early");
  AST_RDY_READ: assert property (
    rd && hit_ctl |=> wb_dat_o[`CM_BIT_RDY] == $past(st_q == ST_READY))
    else $error("ready bit wrong");
  AST_SCALE: assert property (
    ctl_q.sel == 2'b10 && ctl_q.div == 3'h4 |=>
    mul_num_o == 4'h8 && mul_den_o == 3'h5)
    else $error("scale 2/5 wrong");
  AST_INT2_IGNORE: assert property (
    ctl_q.sel == 2'b00 |=> mul_num_o == 4'h2 && mul_den_o == 3'h1)
    else $error("int x2 not unscaled");
  AST_BASE_X4: assert property (
    ctl_q.sel == 2'b11 && ctl_q.div == 3'h0 |=>
    mul_num_o == 4'h4 && mul_src_ext_o)
    else $error("ext x4 wrong");
  AST_PIN_XTAL: assert property (
    xosc_q[2:1] == 2'b11 |=> crystal_pin_a_claim_o &&
    crystal_pin_b_claim_o) else $error("crystal pins not claimed");
  AST_PIN_ONE: assert property (
    xosc_q inside {3'h2, 3'h3, 3'h4, 3'h5} |=>
    !crystal_pin_a_claim_o && crystal_pin_b_claim_o)
    else $error("single pin claim wrong");
  AST_ACK_ONE: assert property (
    wb_ack_o |=> !wb_ack_o) else $error("ack held");

  COV_BRINGUP: cover property (
    st_q == ST_SETTLE ##1 st_q == ST_READY);
  COV_IRQ: cover property ($rose(irq_o));
  COV_XTAL: cover property (crystal_pin_a_claim_o);

endmodule
`default_nettype wire

// File: core/clock_multiplier_control_regs.svh
/*
  Register indices, field positions, reset values and timing counts
  for the clock multiplier control block.
  Assumes a 125 MHz bus clock; included by bare name.
*/
`ifndef CLOCK_MULTIPLIER_CONTROL_REGS_SVH
`define CLOCK_MULTIPLIER_CONTROL_REGS_SVH

// Word indices; byte address is four times the index
`define CM_IDX_CTL 10'h097
`define CM_IDX_XOSC 10'h09F
`define CM_IDX_STAT 10'h0A8
`define CM_IDX_MASK 10'h0A9

`define CM_BIT_EN 7
`define CM_BIT_INIT 6
`define CM_BIT_RDY 5
`define CM_DIV_LSB 2
`define CM_SEL_LSB 0
`define CM_XOSC_LSB 4

`define CM_CTL_RST 8'h00
`define CM_XOSC_RST 3'h0
`define CM_IRQ_RST 2'h0

`define CM_CLK_MHZ 125
`define CM_SETTLE_NS 1000

`endif

// File: core/clock_multiplier_control_pkg.sv
/*
  Types of the clock multiplier control block.
  Assumes clock_multiplier_control_regs.svh supplies all numeric constants.
*/
package clock_multiplier_control_pkg;

  typedef struct packed {
    logic en;
    logic init;
    logic [2:0] div;
    logic [1:0] sel;
  } mul_ctl_t;

  typedef enum logic [1:0] {
    ST_OFF = 2'b00,
    ST_WAIT_INIT = 2'b01,
    ST_SETTLE = 2'b10,
    ST_READY = 2'b11
  } mul_state_t;

  typedef struct packed {
    logic src_ext;
    logic [3:0] num;
    logic [2:0] den;
  } mul_ratio_t;

endpackage

// File: verif/ext_osc_model.sv
/*
  External clock source on the second crystal pin.
  Assumes the claim and mode outputs of the control block.
*/
`timescale 1ns/1ps
`default_nettype none
module ext_osc_model
(
  input wire logic clk_i,
  input wire logic claim_b_i,
  input wire logic digital_i,
  output logic pin_b_o
);
  logic tog_q = 1'b0;
  always_ff @(posedge clk_i)
  begin
    tog_q <= ~tog_q;
  end
  // Drives the toggle on a claimed digital pin, otherwise the inverted toggle, so no stale level
  assign pin_b_o = (claim_b_i && digital_i) ? tog_q : ~tog_q;
endmodule
`default_nettype wire

// File: verif/clock_multiplier_control_tb.sv
/*
  Self-checking bench of the clock multiplier control block.
  Assumes the block's register map header and a 125 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "clock_multiplier_control_regs.svh"
module clock_multiplier_control_tb
  import clock_multiplier_control_pkg::*;
  ;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [11:2] adr = 10'h000;
  logic [31:0] dat = 32'h0;
  logic [3:0] sel = 4'h0;
  logic [3:0] sel_v = 4'hF;
  logic [31:0] rdat, r;
  logic ack, irq, en, rdy, ext, ca, cb, cd, pin;
  logic [3:0] num;
  logic [2:0] den;
  int mismatches = 0;
  int n_compared = 0;
  clock_multiplier_control uut (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .irq_o(irq), .mul_enable_o(en), .mul_ready_o(rdy),
    .mul_src_ext_o(ext), .mul_num_o(num), .mul_den_o(den),
    .crystal_pin_a_claim_o(ca), .crystal_pin_b_claim_o(cb),
    .crystal_pin_b_digital_o(cd));
  ext_osc_model osc (.clk_i(clk_i), .claim_b_i(cb), .digital_i(cd),
    .pin_b_o(pin));
  initial
  begin
    forever #4 clk_i = ~clk_i;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e)
    begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wb(input logic w, input logic [11:2] a,
    input logic [7:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {24'h0, d};
    sel <= sel_v;
    do @(posedge clk_i); while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic t_reset();
    wb(0, `CM_IDX_CTL, 8'h00);
    chk(r, 32'h0);
    chk({irq, en, rdy, ca, cb, cd}, 6'h00);
    chk({num, den}, {4'h2, 3'h1});
    // Low byte not selected: write is refused
    sel_v = 4'hE;
    wb(1, `CM_IDX_CTL, 8'h80);
    sel_v = 4'hF;
    wb(1, `CM_IDX_CTL, 8'h20);
    wb(0, `CM_IDX_CTL, 8'h00);
    chk(r, 32'h0);
    wb(1, 10'h3F0, 8'h5A);
    wb(0, 10'h3F0, 8'h00);
    chk(r, 32'h0);
    chk(irq, 1'b0);
    $display("test reset done");
  endtask
  task automatic t_bringup();
    int w;
    wb(1, `CM_IDX_CTL, 8'hC0);
    wb(0, `CM_IDX_CTL, 8'h00);
    chk(r, 32'h80);
    chk(en, 1'b1);
    wb(1, `CM_IDX_MASK, 8'h01);
    wb(0, `CM_IDX_MASK, 8'h00);
    chk(r, 32'h1);
    wb(1, `CM_IDX_CTL, 8'hC0);
    wb(0, `CM_IDX_CTL, 8'h00);
    chk(r, 32'hC0);
    for (w = 0; w < 300 && rdy !== 1'b1; w++) @(posedge clk_i);
    chk(rdy, 1'b1);
    // Six of the settle edges pass inside the two bus calls, and rdy is seen two edges after the count runs out
    chk(w, (`CM_SETTLE_NS * `CM_CLK_MHZ / 1000) - 4);
    wb(0, `CM_IDX_CTL, 8'h00);
    chk(r, 32'hE0);
    chk(irq, 1'b1);
    wb(0, `CM_IDX_STAT, 8'h00);
    chk(r, 32'h1);
    @(posedge clk_i);
    chk(irq, 1'b0);
    $display("test bringup done");
  endtask
  task automatic t_disable();
    wb(1, `CM_IDX_CTL, 8'h00);
    @(posedge clk_i);
    chk({en, rdy, irq}, 3'b000);
    wb(0, `CM_IDX_STAT, 8'h00);
    chk(r, 32'h2);
    $display("test disable done");
  endtask
  task automatic t_ratio();
    logic [3:0] n;
    logic [2:0] e;
    for (int s = 0; s < 4; s++)
      for (int d = 0; d < 7; d++)
      begin
        wb(1, `CM_IDX_CTL, {3'b100, d[2:0], s[1:0]});
        @(posedge clk_i);
        n = s[1] ? 4'h4 : 4'h2;
        e = 3'h1;
        if (s != 0 && d >= 2)
        begin
          n = 4'(n * 4'h2);
          e = d[2:0] + 3'h1;
        end
        chk({ext, num, den}, {s[0], n, e});
      end
    $display("test ratio done");
  endtask
  task automatic t_xosc();
    for (int m = 0; m < 8; m++)
    begin
      wb(1, `CM_IDX_XOSC, {1'b0, m[2:0], 4'h0});
      @(posedge clk_i);
      chk({ca, cb, cd}, {m[2:1] == 2'b11, m[2:1] != 2'b00,
        m[2:1] == 2'b01});
      wb(0, `CM_IDX_XOSC, 8'h00);
      chk(r, {25'h0, m[2:0], 4'h0});
    end
    $display("test xosc done");
  endtask
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_bringup();
    t_disable();
    t_ratio();
    t_xosc();
    end_of_test();
  end
  // Whole run needs about 420 cycles
  initial
  begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    end_of_test();
  end
endmodule
`default_nettype wire
